// file: common/pulse_shaper_pkg.sv
// Purpose: Shared constants and types of the command pulse output shaper
// Assumes: 100 MHz system clock, 32-bit AHB-Lite register bus
// Notes:   Every offset, field position, reset value and time lives here
package pulse_shaper_pkg;

  // ----------------------------------------------------------------
  // Clock and times
  // ----------------------------------------------------------------
  localparam int unsigned CLK_PERIOD_NS = 10;
  localparam int unsigned DIR_DELAY_US = 200;   // One reversal timer unit
  localparam int unsigned PW_LIMIT_US = 200;    // Limited pulse width
  // Least times round up to whole cycles
  localparam int unsigned DIR_DELAY_CYC_DEF =
    (DIR_DELAY_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned PW_LIMIT_CYC_DEF =
    (PW_LIMIT_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [23:0] MIN_PERIOD = 24'h00_0002;

  // ----------------------------------------------------------------
  // Register map (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [7:0] OFS_ENV1 = 8'h00;
  localparam logic [7:0] OFS_MODE = 8'h04;
  localparam logic [7:0] OFS_STAT = 8'h08;

  // Environment register fields
  localparam int unsigned ENV_FMT_LSB = 0;    // 3-bit output format
  localparam int unsigned ENV_DTMF_BIT = 25;  // 0 enables reversal delay
  localparam int unsigned ENV_MREV_BIT = 26;  // 1 swaps travel waveforms
  localparam int unsigned ENV_PDTC_BIT = 27;  // 0 enables width limiting
  // Mode register fields
  localparam int unsigned MODE_METM_BIT = 0;  // Completion select
  // Status register fields
  localparam int unsigned STAT_BUSY_BIT = 0;
  localparam int unsigned STAT_DONE_BIT = 1;  // Sticky, write 1 to clear
  localparam int unsigned STAT_HEAD_BIT = 2;
  localparam int unsigned STAT_OUT_BIT = 3;
  localparam int unsigned STAT_DIRP_BIT = 4;
  localparam int unsigned STAT_PH_LSB = 8;

  localparam logic [31:0] ENV1_RST = 32'h0000_0000;
  localparam logic [31:0] MODE_RST = 32'h0000_0000;

  // ----------------------------------------------------------------
  // Output formats
  // ----------------------------------------------------------------
  localparam logic [2:0] FMT_CMN_LO = 3'h0;   // Pulse low, dir high = +
  localparam logic [2:0] FMT_CMN_HI = 3'h1;   // Pulse high, dir high = +
  localparam logic [2:0] FMT_CMNI_LO = 3'h2;  // Pulse low, dir inverted
  localparam logic [2:0] FMT_CMNI_HI = 3'h3;  // Pulse high, dir inverted
  localparam logic [2:0] FMT_TWO_LO = 3'h4;   // Two-pulse, idle high
  localparam logic [2:0] FMT_QUAD_A = 3'h5;   // Quadrature, pulse pin leads
  localparam logic [2:0] FMT_QUAD_B = 3'h6;   // Quadrature, heading leads
  localparam logic [2:0] FMT_TWO_HI = 3'h7;   // Two-pulse, idle low

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_WAIT = 2'b01,
    ST_HIGH = 2'b10,
    ST_LOW  = 2'b11
  } eng_state_t;

  typedef struct packed {
    logic        dir;     // 1 = positive travel
    logic        last;    // Final step of the operation
    logic [23:0] period;  // Pulse cycle in clock cycles
  } step_cmd_t;

  typedef struct packed {
    logic pulse_pin;
    logic heading_pin;
  } pins_t;

endpackage

// file: rtl/command_pulse_output_shaper.sv
// Purpose: One axis output stage turning step commands into driver pulses
// Assumes: Single 100 MHz clock; step commands from an internal generator
// Notes:   Registers over AHB-Lite, zero wait states, always OKAY
`timescale 1ns/1ps
`default_nettype none
module command_pulse_output_shaper #(
  parameter int unsigned DIR_DELAY_CYC =
    pulse_shaper_pkg::DIR_DELAY_CYC_DEF,
  parameter int unsigned PW_LIMIT_CYC =
    pulse_shaper_pkg::PW_LIMIT_CYC_DEF
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire logic step_valid,
  input wire pulse_shaper_pkg::step_cmd_t step_cmd,
  output logic step_ready,
  output logic pulse_pin,
  output logic heading_pin,
  output logic busy,
  output logic op_done
);

  // ----------------------------------------------------------------
  // Register bus
  // ----------------------------------------------------------------
  logic [31:0] env_r;
  logic [31:0] env_nxt;
  logic metm_r;
  logic metm_nxt;
  logic done_flag_r;
  logic done_flag_nxt;
  logic [31:0] rdata_r;
  logic [31:0] rdata_nxt;
  logic wr_pend_r;
  logic wr_pend_nxt;
  logic [7:0] wr_addr_r;
  logic [7:0] wr_addr_nxt;
  logic [31:0] stat_word;
  logic [2:0] fmt;
  logic dtmf;
  logic mrev;
  logic pdtc;
  logic addr_ok;
  logic done_evt;

  // Engine state, declared early for the status word
  pulse_shaper_pkg::eng_state_t state_r;
  pulse_shaper_pkg::eng_state_t state_nxt;
  logic [23:0] cnt_r;
  logic [23:0] cnt_nxt;
  logic [23:0] width_r;
  logic [23:0] width_nxt;
  logic [23:0] period_r;
  logic [23:0] period_nxt;
  logic last_r;
  logic last_nxt;
  logic dir_eff_r;
  logic dir_eff_nxt;
  logic [1:0] phase_r;
  logic [1:0] phase_nxt;
  logic done_r;
  logic done_nxt;
  pulse_shaper_pkg::pins_t pins;

  assign fmt = env_r[pulse_shaper_pkg::ENV_FMT_LSB +: 3];
  assign dtmf = env_r[pulse_shaper_pkg::ENV_DTMF_BIT];
  assign mrev = env_r[pulse_shaper_pkg::ENV_MREV_BIT];
  assign pdtc = env_r[pulse_shaper_pkg::ENV_PDTC_BIT];
  assign hreadyout = 1'b1;  // Every access completes without wait
  assign hresp = 1'b0;
  assign hrdata = rdata_r;
  assign addr_ok = hsel && htrans[1] && hready;
  assign done_evt = done_r;

  // Status word; the environment register is write only and reads zero
  always_comb begin
    stat_word = 32'h0000_0000;
    stat_word[pulse_shaper_pkg::STAT_BUSY_BIT] =
      (state_r != pulse_shaper_pkg::ST_IDLE);
    stat_word[pulse_shaper_pkg::STAT_DONE_BIT] = done_flag_r;
    stat_word[pulse_shaper_pkg::STAT_HEAD_BIT] = dir_eff_r;
    stat_word[pulse_shaper_pkg::STAT_OUT_BIT] = pins.pulse_pin;
    stat_word[pulse_shaper_pkg::STAT_DIRP_BIT] = pins.heading_pin;
    stat_word[pulse_shaper_pkg::STAT_PH_LSB +: 2] = phase_r;
  end

  // Address phase is latched; write data lands one cycle later.
  // Read data is captured in the address phase so hrdata is a flop.
  always_comb begin
    env_nxt = env_r;
    metm_nxt = metm_r;
    done_flag_nxt = done_flag_r;
    rdata_nxt = rdata_r;
    wr_pend_nxt = addr_ok && hwrite;
    wr_addr_nxt = addr_ok ? haddr[7:0] : wr_addr_r;
    if (wr_pend_r) begin
      case (wr_addr_r)
        pulse_shaper_pkg::OFS_ENV1: env_nxt = hwdata;
        pulse_shaper_pkg::OFS_MODE:
          metm_nxt = hwdata[pulse_shaper_pkg::MODE_METM_BIT];
        pulse_shaper_pkg::OFS_STAT:
          if (hwdata[pulse_shaper_pkg::STAT_DONE_BIT]) begin
            done_flag_nxt = 1'b0;
          end
        default: env_nxt = env_r;
      endcase
    end
    // Completion arriving with a clear is kept: the set wins
    if (done_evt) begin
      done_flag_nxt = 1'b1;
    end
    if (addr_ok && !hwrite) begin
      case (haddr[7:0])
        pulse_shaper_pkg::OFS_MODE: begin
          rdata_nxt = 32'h0000_0000;
          rdata_nxt[pulse_shaper_pkg::MODE_METM_BIT] = metm_r;
        end
        pulse_shaper_pkg::OFS_STAT: rdata_nxt = stat_word;
        default: rdata_nxt = 32'h0000_0000;
      endcase
    end
  end

  // Bus registers
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      env_r <= pulse_shaper_pkg::ENV1_RST;
      metm_r <= pulse_shaper_pkg::MODE_RST[pulse_shaper_pkg::MODE_METM_BIT];
      done_flag_r <= 1'b0;
      rdata_r <= 32'h0000_0000;
      wr_pend_r <= 1'b0;
      wr_addr_r <= 8'h00;
    end else begin
      env_r <= env_nxt;
      metm_r <= metm_nxt;
      done_flag_r <= done_flag_nxt;
      rdata_r <= rdata_nxt;
      wr_pend_r <= wr_pend_nxt;
      wr_addr_r <= wr_addr_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Pulse engine
  // ----------------------------------------------------------------
  // Active width: half the cycle, or the fixed limit when limiting is on
  // and half the cycle would exceed it (slow rates only).
  function automatic logic [23:0] width_of(input logic [23:0] per,
                                           input logic lim_off);
    logic [23:0] half;
    half = per >> 1;
    if (!lim_off && (half > 24'(PW_LIMIT_CYC))) begin
      width_of = 24'(PW_LIMIT_CYC);
    end else begin
      width_of = half;
    end
  endfunction

  function automatic logic [23:0] clamp_period(input logic [23:0] per);
    clamp_period = (per < pulse_shaper_pkg::MIN_PERIOD) ?
      pulse_shaper_pkg::MIN_PERIOD : per;
  endfunction

  assign step_ready = (state_r == pulse_shaper_pkg::ST_IDLE);

  // Next state of the engine
  always_comb begin
    state_nxt = state_r;
    cnt_nxt = cnt_r + 24'h00_0001;
    width_nxt = width_r;
    period_nxt = period_r;
    last_nxt = last_r;
    dir_eff_nxt = dir_eff_r;
    phase_nxt = phase_r;
    done_nxt = 1'b0;
    case (state_r)
      pulse_shaper_pkg::ST_IDLE: begin
        cnt_nxt = 24'h00_0000;
        if (step_valid) begin
          period_nxt = clamp_period(step_cmd.period);
          width_nxt = width_of(clamp_period(step_cmd.period), pdtc);
          last_nxt = step_cmd.last;
          dir_eff_nxt = step_cmd.dir ^ mrev;
          if (((step_cmd.dir ^ mrev) != dir_eff_r) && !dtmf) begin
            state_nxt = pulse_shaper_pkg::ST_WAIT;
          end else begin
            state_nxt = pulse_shaper_pkg::ST_HIGH;
            phase_nxt = (step_cmd.dir ^ mrev) ? phase_r + 2'd1 :
                                                 phase_r - 2'd1;
          end
        end
      end
      pulse_shaper_pkg::ST_WAIT: begin
        if (cnt_r == 24'(DIR_DELAY_CYC - 1)) begin
          cnt_nxt = 24'h00_0000;
          state_nxt = pulse_shaper_pkg::ST_HIGH;
          phase_nxt = dir_eff_r ? phase_r + 2'd1 : phase_r - 2'd1;
        end
      end
      pulse_shaper_pkg::ST_HIGH: begin
        if (cnt_r == width_r - 24'h00_0001) begin
          if (last_r && metm_r) begin
            state_nxt = pulse_shaper_pkg::ST_IDLE;
            done_nxt = 1'b1;
          end else begin
            state_nxt = pulse_shaper_pkg::ST_LOW;
          end
        end
      end
      pulse_shaper_pkg::ST_LOW: begin
        if (cnt_r == period_r - width_r - 24'h00_0001) begin
          state_nxt = pulse_shaper_pkg::ST_IDLE;
          done_nxt = last_r;
        end
      end
      default: begin
        state_nxt = pulse_shaper_pkg::ST_IDLE;
      end
    endcase
    if (state_nxt != state_r) begin
      cnt_nxt = 24'h00_0000;
    end
  end

  // Engine registers; heading starts positive to match pins at reset
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_r <= pulse_shaper_pkg::ST_IDLE;
      cnt_r <= 24'h00_0000;
      width_r <= 24'h00_0001;
      period_r <= pulse_shaper_pkg::MIN_PERIOD;
      last_r <= 1'b0;
      dir_eff_r <= 1'b1;
      phase_r <= 2'b00;
      done_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      cnt_r <= cnt_nxt;
      width_r <= width_nxt;
      period_r <= period_nxt;
      last_r <= last_nxt;
      dir_eff_r <= dir_eff_nxt;
      phase_r <= phase_nxt;
      done_r <= done_nxt;
    end
  end

  // Pin mapping; in the common formats the heading level follows dir_eff_r one cycle after it turns
  pin_encoder u_pin_encoder (
    .hclk(hclk),
    .hresetn(hresetn),
    .fmt(fmt),
    .dir_eff(dir_eff_r),
    .pulse_on(state_r == pulse_shaper_pkg::ST_HIGH),
    .phase(phase_r),
    .pins(pins)
  );

  assign pulse_pin = pins.pulse_pin;
  assign heading_pin = pins.heading_pin;
  assign busy = (state_r != pulse_shaper_pkg::ST_IDLE);
  assign op_done = done_r;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  sequence s_in_high;
    state_r == pulse_shaper_pkg::ST_HIGH;
  endsequence

  sequence s_start_step;
    $changed(phase_r);
  endsequence

  AST_COMMON_PULSE: assert property (
    s_in_high and $stable(fmt) and (fmt[2] == 1'b0) |=>
      pulse_pin == $past(fmt[0]))
    else $error("common pulse level wrong");

  AST_HEADING_LEVEL: assert property (
    s_in_high and $stable(fmt) and $stable(dir_eff_r) and !fmt[2] |=>
      heading_pin == ($past(dir_eff_r) ^ $past(fmt[1])))
    else $error("heading level wrong");

  AST_TWO_PULSE: assert property (
    s_in_high and $stable(fmt) and fmt == pulse_shaper_pkg::FMT_TWO_LO |=>
      (pulse_pin == !$past(dir_eff_r)) && (heading_pin == $past(dir_eff_r)))
    else $error("two-pulse pins wrong");

  AST_QUAD_STEP: assert property (
    s_start_step |-> (phase_r == $past(phase_r) + 2'd1) ||
                     (phase_r == $past(phase_r) - 2'd1))
    else $error("quadrature phase jumped");

  AST_QUAD_LEAD: assert property (
    s_start_step and dir_eff_r |-> phase_r == $past(phase_r) + 2'd1)
    else $error("positive travel must count up");

  AST_DIR_HOLD: assert property (
    $past(state_r) == pulse_shaper_pkg::ST_WAIT and s_in_high |->
      $past(cnt_r) == 24'(DIR_DELAY_CYC - 1))
    else $error("reversal delay cut short");

  AST_REVERSAL: assert property (
    step_ready && step_valid |=>
      dir_eff_r == ($past(step_cmd.dir) ^ $past(mrev)))
    else $error("reversal swap wrong");

  AST_WIDTH: assert property (
    step_ready && step_valid |=>
      width_r == width_of(clamp_period($past(step_cmd.period)),
                          $past(pdtc)))
    else $error("pulse width wrong");

  AST_DONE_LIMIT: assert property (
    s_in_high and last_r and metm_r and !pdtc |->
      cnt_r < 24'(PW_LIMIT_CYC))
    else $error("completion later than width limit");

  AST_DONE_POINT: assert property (
    op_done |-> ($past(state_r) == pulse_shaper_pkg::ST_HIGH && $past(metm_r))
             || ($past(state_r) == pulse_shaper_pkg::ST_LOW))
    else $error("completion at wrong point");

endmodule
`default_nettype wire

// file: rtl/pin_encoder.sv
// Purpose: Maps the engine's pulse, heading and phase onto the two pins
// Assumes: Inputs change on hclk; pins are registered
// Notes:   Both pins sit high during and right after reset
`timescale 1ns/1ps
`default_nettype none
module pin_encoder (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic [2:0] fmt,
  input wire logic dir_eff,
  input wire logic pulse_on,
  input wire logic [1:0] phase,
  output pulse_shaper_pkg::pins_t pins
);

  // ----------------------------------------------------------------
  // Format decode
  // ----------------------------------------------------------------
  function automatic logic is_common(input logic [2:0] f);
    is_common = (f[2] == 1'b0);
  endfunction

  pulse_shaper_pkg::pins_t pins_nxt;

  // Quadrature in gray order: b leads a when the phase counts up
  logic quad_a;
  logic quad_b;
  assign quad_a = phase[1];
  assign quad_b = phase[1] ^ phase[0];

  // Pin levels for each format
  always_comb begin
    pins_nxt = pins;
    if (is_common(fmt)) begin
      pins_nxt.pulse_pin = pulse_on ? fmt[0] : ~fmt[0];
      pins_nxt.heading_pin = dir_eff ^ fmt[1];
    end else begin
      case (fmt)
        pulse_shaper_pkg::FMT_TWO_LO: begin
          pins_nxt.pulse_pin = ~(pulse_on & dir_eff);
          pins_nxt.heading_pin = ~(pulse_on & ~dir_eff);
        end
        pulse_shaper_pkg::FMT_TWO_HI: begin
          pins_nxt.pulse_pin = pulse_on & dir_eff;
          pins_nxt.heading_pin = pulse_on & ~dir_eff;
        end
        pulse_shaper_pkg::FMT_QUAD_A: begin
          pins_nxt.pulse_pin = quad_b;
          pins_nxt.heading_pin = quad_a;
        end
        pulse_shaper_pkg::FMT_QUAD_B: begin
          pins_nxt.pulse_pin = quad_a;
          pins_nxt.heading_pin = quad_b;
        end
        default: begin
          pins_nxt = pins;
        end
      endcase
    end
  end

  // Registered pins keep glitches off the driver inputs
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pins <= '{pulse_pin: 1'b1, heading_pin: 1'b1};
    end else begin
      pins <= pins_nxt;
    end
  end

endmodule
`default_nettype wire

// file: tb/command_pulse_output_shaper_bench.sv
// Purpose: Self-checking bench for the command pulse output shaper
// Assumes: Zero wait AHB-Lite slave; small delay and width parameters
// Notes:   Short counts keep the run brief; expectations use them
`timescale 1ns/1ps
`default_nettype none
module command_pulse_output_shaper_bench;
  localparam int unsigned DLY = 20;
  localparam int unsigned PWL = 16;
  logic hclk = 1'h0;
  logic hresetn = 1'h0;
  logic hsel = 1'h0;
  logic hwrite = 1'h0;
  logic step_valid = 1'h0;
  logic [31:0] haddr = 32'h0000_0000;
  logic [31:0] hwdata = 32'h0000_0000;
  logic [1:0] htrans = 2'h0;
  logic [2:0] hsize = 3'h2;
  pulse_shaper_pkg::step_cmd_t step_cmd = '0;
  logic hreadyout, hresp, step_ready, pulse_pin, heading_pin, busy, op_done;
  logic [31:0] hrdata;
  int unsigned pf, hf, lw, hw, th, tp;
  int n_errors = 0;
  int n_checks = 0;

  // Clock of 100 MHz
  always #5 hclk = ~hclk;

  command_pulse_output_shaper #(.DIR_DELAY_CYC(DLY), .PW_LIMIT_CYC(PWL))
    i_command_pulse_output_shaper (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
    .hrdata(hrdata), .step_valid(step_valid), .step_cmd(step_cmd),
    .step_ready(step_ready), .pulse_pin(pulse_pin),
    .heading_pin(heading_pin), .busy(busy), .op_done(op_done)
  );

  motor_driver_model i_motor_driver_model (
    .hclk(hclk), .hresetn(hresetn), .pulse_pin(pulse_pin),
    .heading_pin(heading_pin), .pulse_falls(pf), .head_falls(hf),
    .low_width(lw), .high_width(hw), .t_head(th), .t_pfall(tp)
  );

  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic check(input string what, input logic [31:0] seen,
                       input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic finish_test();
    $display("checks %0d mismatches %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  task automatic timed_out();
    n_errors++;
    $display("BAD wait expected answer seen timeout");
    finish_test();
  endtask

  // One single word transfer; hready is waited for in both phases
  task automatic bus(input logic wr, input logic [7:0] a,
                     input logic [31:0] wd, output logic [31:0] rd);
    int n;
    n = 0;
    @(posedge hclk);
    hsel <= 1'h1;
    htrans <= 2'h2;
    haddr <= {24'h00_0000, a};
    hwrite <= wr;
    do begin @(posedge hclk); n++; end while (hreadyout !== 1'h1 && n < 99);
    hsel <= 1'h0;
    htrans <= 2'h0;
    hwdata <= wd;
    do begin @(posedge hclk); n++; end while (hreadyout !== 1'h1 && n < 99);
    rd = hrdata;
    if (n >= 99) timed_out();
  endtask

  // Writes the environment word and lets the pins settle
  task automatic setenv(input logic [2:0] f, input logic dl,
                        input logic rv, input logic wl);
    logic [31:0] v;
    v = 32'h0000_0000;
    v[2:0] = f;
    v[pulse_shaper_pkg::ENV_DTMF_BIT] = dl;
    v[pulse_shaper_pkg::ENV_MREV_BIT] = rv;
    v[pulse_shaper_pkg::ENV_PDTC_BIT] = wl;
    bus(1'h1, pulse_shaper_pkg::OFS_ENV1, v, v);
    repeat (4) @(posedge hclk);
  endtask

  // Offers one step, returns cycles from acceptance to completion
  task automatic step(input logic d, input logic l, input logic [23:0] p,
                      output int t);
    int n;
    n = 0;
    @(posedge hclk);
    step_valid <= 1'h1;
    step_cmd <= {d, l, p};
    do begin @(negedge hclk); n++; end while (step_ready !== 1'h1 && n < 9000);
    @(posedge hclk);
    step_valid <= 1'h0;
    t = 0;
    do begin @(negedge hclk); t++; end while (l && op_done !== 1'h1 && t < 9000);
    do begin @(negedge hclk); n++; end while (busy !== 1'h0 && n < 9000);
    if (n >= 9000 || t >= 9000) timed_out();
    repeat (3) @(negedge hclk);
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_regs();
    logic [31:0] r;
    bus(1'h0, pulse_shaper_pkg::OFS_ENV1, 32'h0000_0000, r);
    check("env1 read", r, 32'h0000_0000);
    bus(1'h0, pulse_shaper_pkg::OFS_MODE, 32'h0000_0000, r);
    check("mode reset", r, 32'h0000_0000);
    bus(1'h0, 8'h10, 32'h0000_0000, r);
    check("unmapped read", r, 32'h0000_0000);
    check("okay resp", hresp, 32'h0000_0000);
    $display("register test over");
  endtask

  // Common and two-pulse formats in both directions, swap off and on
  task automatic t_formats();
    logic [2:0] fl [6] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h4, 3'h7};
    int t, p0, h0;
    logic e;
    for (int m = 0; m < 2; m++) begin
      foreach (fl[i]) begin
        setenv(fl[i], 1'h1, m[0], 1'h1);
        for (int d = 0; d < 2; d++) begin
          p0 = pf;
          h0 = hf;
          step(d[0], 1'h0, 24'h00_0028, t);
          step(d[0], 1'h1, 24'h00_0028, t);
          e = d[0] ^ m[0];
          if (!fl[i][2]) begin
            check("cmn pulses", pf - p0, 2);
            check("cmn heading", heading_pin, e ^ fl[i][1]);
            check("cmn width", fl[i][0] ? hw : lw, 20);
          end else begin
            check("two pos", pf - p0, e ? 2 : 0);
            check("two neg", hf - h0, e ? 0 : 2);
          end
        end
      end
    end
    $display("format test over");
  endtask

  // Each step moves exactly one pin; the leading pin decides which
  task automatic t_quad();
    logic p, h, pm;
    int t;
    for (int f = 5; f < 7; f++) begin
      setenv(f[2:0], 1'h1, 1'h0, 1'h1);
      for (int d = 1; d >= 0; d--) begin
        for (int k = 0; k < 4; k++) begin
          p = pulse_pin;
          h = heading_pin;
          step(d[0], 1'h0, 24'h00_0010, t);
          pm = (p == h) ^ !d[0] ^ (f == 6);
          check("quad pulse", pulse_pin, p ^ pm);
          check("quad heading", heading_pin, h ^ !pm);
        end
      end
    end
    $display("quadrature test over");
  endtask

  task automatic t_width();
    int t, dd;
    setenv(3'h0, 1'h1, 1'h0, 1'h0);
    step(1'h1, 1'h1, 24'h00_0040, t);
    check("limited width", lw, PWL);
    step(1'h1, 1'h1, 24'h00_0014, t);
    check("fast width", lw, 10);
    setenv(3'h0, 1'h0, 1'h0, 1'h1);
    step(1'h0, 1'h1, 24'h00_0010, t);
    dd = int'(tp) - int'(th);
    check("turn delay", dd >= DLY && dd <= DLY + 3, 1);
    setenv(3'h0, 1'h1, 1'h0, 1'h1);
    step(1'h1, 1'h1, 24'h00_0010, t);
    dd = int'(tp) - int'(th);
    check("no turn delay", dd >= 0 && dd <= 3, 1);
    $display("width and delay test over");
  endtask

  // Completion at end of cycle, then at end of active width
  task automatic t_done();
    int t0, t1, t2;
    logic [31:0] r;
    step(1'h1, 1'h1, 24'h00_0028, t0);
    bus(1'h1, pulse_shaper_pkg::OFS_MODE, 32'h0000_0001, r);
    bus(1'h0, pulse_shaper_pkg::OFS_MODE, 32'h0000_0000, r);
    check("mode select", r, 32'h0000_0001);
    step(1'h1, 1'h1, 24'h00_0028, t1);
    check("done gap", t0 - t1 >= 19 && t0 - t1 <= 21, 1);
    setenv(3'h0, 1'h1, 1'h0, 1'h0);
    step(1'h1, 1'h1, 24'h00_00C8, t2);
    check("done limited", t2 >= PWL && t2 <= PWL + 5, 1);
    bus(1'h0, pulse_shaper_pkg::OFS_STAT, 32'h0000_0000, r);
    check("done sticky", r[pulse_shaper_pkg::STAT_DONE_BIT], 1);
    bus(1'h1, pulse_shaper_pkg::OFS_STAT, 32'h0000_0002, r);
    bus(1'h0, pulse_shaper_pkg::OFS_STAT, 32'h0000_0000, r);
    check("done cleared", r[pulse_shaper_pkg::STAT_DONE_BIT], 0);
    $display("completion test over");
  endtask

  // Main sequence
  initial begin
    repeat (12) @(posedge hclk);
    hresetn <= 1'h1;
    t_regs();
    t_formats();
    t_quad();
    t_width();
    t_done();
    finish_test();
  end
endmodule
`default_nettype wire

// file: tb/motor_driver_model.sv
// Purpose: Behavioural motor driver that watches the two command pins
// Assumes: Pins are sampled on the rising edge of hclk
// Notes:   Reports edge counts, last run lengths and edge times
`timescale 1ns/1ps
`default_nettype none
module motor_driver_model (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic pulse_pin,
  input wire logic heading_pin,
  output int unsigned pulse_falls,
  output int unsigned head_falls,
  output int unsigned low_width,
  output int unsigned high_width,
  output int unsigned t_head,
  output int unsigned t_pfall
);
  // ----------------------------------------------------------------
  // Edge tracking
  // ----------------------------------------------------------------
  int unsigned cyc;
  int unsigned run;
  logic p_q;
  logic h_q;

  // Both pins idle high out of reset, so start the history high
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cyc <= 0;
      run <= 0;
      p_q <= 1'h1;
      h_q <= 1'h1;
      pulse_falls <= 0;
      head_falls <= 0;
      low_width <= 0;
      high_width <= 0;
      t_head <= 0;
      t_pfall <= 0;
    end else begin
      cyc <= cyc + 1;
      p_q <= pulse_pin;
      h_q <= heading_pin;
      if (pulse_pin != p_q) begin
        run <= 1;
        if (p_q) begin
          high_width <= run;
        end else begin
          low_width <= run;
        end
        if (!pulse_pin) begin
          pulse_falls <= pulse_falls + 1;
          t_pfall <= cyc;
        end
      end else begin
        run <= run + 1;
      end
      if (heading_pin != h_q) begin
        t_head <= cyc;
        if (!heading_pin) begin
          head_falls <= head_falls + 1;
        end
      end
    end
  end
endmodule
`default_nettype wire
